// ---- camera_model.sv ----
// Behavioural camera on the far side: each expose pulse outside a running frame starts one frame of pixel words.
// Assumes the pixel bus runs on the acquisition clock; kick starts a frame at once.
`timescale 1ns/1ps
`default_nettype none
module camera_model #(
    parameter int LAG = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic expose,
    input wire logic kick,
    input wire logic [7:0] words,
    output logic fval,
    output logic [31:0] pix_data,
    output logic pix_valid,
    input wire logic pix_ready
);
    logic ex_q;
    int lag;
    int sent;
    int gap;
    int cyc;
    always @(posedge clk) begin
        ex_q <= expose;
        cyc <= cyc + 1;
        if (rst_n && fval && !pix_valid && sent < int'(words)) begin
            pix_data <= 32'h100 + 32'(sent);
        end else if (!pix_valid || pix_ready) begin
            // Idle data keeps changing so a stale word cannot pass for a fresh one
            pix_data <= 32'hdead0000 ^ 32'(cyc);
        end
        if (!rst_n) begin
            fval <= 1'b0;
            pix_valid <= 1'b0;
            lag <= 0;
        end else if (!fval) begin
            if (expose && !ex_q) begin
                lag <= LAG;
            end else if (lag > 0) begin
                lag <= lag - 1;
            end
            if (kick || lag == 1) begin
                fval <= 1'b1;
                sent <= 0;
                // Frame valid crosses two sync stages, so pixels wait for it
                gap <= 4;
            end
        end else if (pix_valid) begin
            if (pix_ready) begin
                pix_valid <= 1'b0;
                sent <= sent + 1;
            end
        end else if (gap > 0) begin
            gap <= gap - 1;
        end else if (sent < int'(words)) begin
            pix_valid <= 1'b1;
        end else begin
            fval <= 1'b0;
        end
    end
endmodule // camera_model
`default_nettype wire

// ---- frame_timer_pkg.sv ----
// Shared constants and types for the frame trigger timer and sync tagger.
// Assumes one 100 MHz acquisition clock and a 32-bit AXI4-Lite register bus.
package frame_timer_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int EXPOSE_PULSE_NS = 1000;
    localparam logic [7:0] EXPOSE_PULSE_CYC =
        8'((EXPOSE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int HDR_WORDS = 2;
    localparam int ADDR_W = 8;
    typedef logic [ADDR_W-1:0] addr_t;
    localparam addr_t REG_CTRL = 8'h00;
    localparam addr_t REG_PERIOD = 8'h04;
    localparam addr_t REG_FSIZE = 8'h08;
    localparam addr_t REG_STATUS = 8'h0c;
    localparam addr_t REG_FRAMES = 8'h10;
    localparam addr_t REG_TIMER = 8'h14;
    localparam int CTRL_TMODE_LSB = 0;
    localparam int CTRL_FSYNC_LSB = 2;
    localparam int CTRL_HPOS_LSB = 4;
    localparam int CTRL_TSRC_LSB = 8;
    localparam logic [7:0] TSRC_BOARD = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h0;
    localparam logic [31:0] PERIOD_RST = 32'h0;
    localparam logic [31:0] FSIZE_RST = 32'h0;
    localparam int STAT_SYNC_BIT = 0;
    localparam int STAT_TMO_BIT = 1;
    localparam int STAT_EXPOSE_BIT = 2;
    localparam int STAT_ARMED_BIT = 3;
    // Marker value is arbitrary
    localparam logic [31:0] SOF_MARKER = 32'h5a5a_c3c3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {TM_OFF = 2'h0, TM_PERIODIC = 2'h1, TM_FVWAIT = 2'h2} tmode_t;
    typedef enum logic [1:0] {FS_OFF = 2'h0, FS_ON = 2'h1, FS_TIMEOUT = 2'h2} fsync_t;
    typedef enum logic [1:0] {HP_WITHIN = 2'h0, HP_BEFORE = 2'h1, HP_AFTER = 2'h2} hpos_t;
    typedef enum logic [1:0] {
        TG_IDLE = 2'h0, TG_HEAD = 2'h1, TG_PIX = 2'h3, TG_TAIL = 2'h2
    } tag_state_t;
    typedef struct packed {
        logic tag;
        logic [31:0] data;
    } word_t;
endpackage

// ---- frame_trigger_timer_and_sync_tagger.sv ----
// Frame trigger timer and frame-sync tagger of a camera framegrabber.
// Assumes one acquisition clock, an AXI4-Lite master, a same-clock pixel source
// and an asynchronous frame valid pin.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Periodic mode fires trigger pulses continuously, one interval apart.
// - Frame-valid wait mode holds the next trigger until the timer reaches zero.
// - With no timer mode and board triggering, trigger on frame valid rising.
// - Timer modes run only when trigger source control selects board triggering.
// - Trigger pulses drive the camera expose line.
// - Wait mode measures the interval from the start of the previous readout.
// - Tagging puts two header words with a fixed start-of-frame marker into each frame; within the data they replace the first two pixel words.
// - Tagging flags frames whose word count differs from the frame size, and pixels accepted outside a frame.
// - Timeout-emulation mode also reports each sync error as acquisition timeout.
// - Header sits within, before or after the image data, as configured.
module frame_trigger_timer_and_sync_tagger #(
    parameter int FIFO_DEPTH = frame_timer_pkg::FIFO_DEPTH_DEF,
    parameter logic [7:0] PULSE_CYCLES = frame_timer_pkg::EXPOSE_PULSE_CYC
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire frame_timer_pkg::addr_t AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire frame_timer_pkg::addr_t ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic FVAL_IN,
    input wire logic [31:0] PIX_DATA,
    input wire logic PIX_VALID,
    output logic PIX_READY,
    output frame_timer_pkg::word_t OUT_WORD,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic EXPOSE,
    output logic SYNC_ERR,
    output logic ACQ_TIMEOUT
);
    import frame_timer_pkg::*;
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int PW = $clog2(US_CYCLES);

    typedef struct packed {
        logic fval_s1;
        logic fval_s2;
        logic fval_d;
        logic awready;
        logic wready;
        logic aw_hold;
        logic w_hold;
        addr_t awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] period;
        logic [31:0] fsize;
        logic sync_flag;
        logic tmo_flag;
        logic [PW-1:0] pre;
        logic [31:0] timer;
        logic armed;
        logic [7:0] pulse;
        logic expose;
        tag_state_t st;
        logic [1:0] hcnt;
        logic [31:0] wcnt;
        logic [31:0] frames;
        logic pix_ready;
        logic push_valid;
        word_t push_word;
        logic sync_err;
        logic acq_tmo;
    } state_t;

    state_t s, n;
    logic [LW-1:0] fifo_level;
    logic fifo_ready;
    logic board, fval_rise, fval_fall, tagging, accept, trig, wr_go, space_ok;
    logic [31:0] clr;
    tmode_t tm;
    fsync_t fsm;
    hpos_t hp;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] strb);
        wmerge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                wmerge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // Word 0 carries the marker, word 1 the frame number
    function automatic word_t hdr_word(input logic [1:0] idx, input logic [31:0] frames);
        hdr_word.tag = (idx == 2'h0);
        hdr_word.data = (idx == 2'h0) ? SOF_MARKER : frames;
    endfunction

    always_comb begin
        n = s;
        clr = '0;
        tm = tmode_t'(s.ctrl[CTRL_TMODE_LSB +: 2]);
        fsm = fsync_t'(s.ctrl[CTRL_FSYNC_LSB +: 2]);
        hp = hpos_t'(s.ctrl[CTRL_HPOS_LSB +: 2]);
        board = (s.ctrl[CTRL_TSRC_LSB +: 8] == TSRC_BOARD);
        tagging = (fsm == FS_ON) || (fsm == FS_TIMEOUT);
        n.fval_s1 = FVAL_IN;
        n.fval_s2 = s.fval_s1;
        n.fval_d = s.fval_s2;
        fval_rise = s.fval_s2 && !s.fval_d;
        fval_fall = !s.fval_s2 && s.fval_d;

        // Register writes: address and data may arrive in either order
        if (AWVALID && s.awready) begin
            n.aw_hold = 1'b1;
            n.awaddr = AWADDR;
        end
        if (WVALID && s.wready) begin
            n.w_hold = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        if (s.bvalid && BREADY) begin
            n.bvalid = 1'b0;
        end
        wr_go = s.aw_hold && s.w_hold && !s.bvalid;
        if (wr_go) begin
            n.aw_hold = 1'b0;
            n.w_hold = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (s.awaddr)
                REG_CTRL: n.ctrl = wmerge(s.ctrl, s.wdata, s.wstrb);
                REG_PERIOD: n.period = wmerge(s.period, s.wdata, s.wstrb);
                REG_FSIZE: n.fsize = wmerge(s.fsize, s.wdata, s.wstrb);
                REG_STATUS: clr = wmerge(32'h0, s.wdata, s.wstrb);
                REG_FRAMES, REG_TIMER: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_hold;
        n.wready = !n.w_hold;

        // Register reads
        if (s.rvalid && RREADY) begin
            n.rvalid = 1'b0;
        end
        if (ARVALID && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            case (ARADDR)
                REG_CTRL: n.rdata = s.ctrl;
                REG_PERIOD: n.rdata = s.period;
                REG_FSIZE: n.rdata = s.fsize;
                REG_STATUS: begin
                    n.rdata[STAT_SYNC_BIT] = s.sync_flag;
                    n.rdata[STAT_TMO_BIT] = s.tmo_flag;
                    n.rdata[STAT_EXPOSE_BIT] = s.expose;
                    n.rdata[STAT_ARMED_BIT] = s.armed;
                end
                REG_FRAMES: n.rdata = s.frames;
                REG_TIMER: n.rdata = s.timer;
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        n.arready = !n.rvalid;

        // Trigger generation; non-board sources leave the line to the camera
        trig = board && (((tm == TM_PERIODIC) && (s.timer == '0)) ||
               ((tm == TM_FVWAIT) && s.armed && (s.timer == '0)) ||
               ((tm == TM_OFF) && fval_rise));
        // One tick per microsecond; a restart counts its own load cycle so the period stays exact
        if (trig || (tm == TM_FVWAIT && fval_rise)) begin
            n.pre = PW'(US_CYCLES - 2);
        end else if (s.pre == '0) begin
            n.pre = PW'(US_CYCLES - 1);
        end else begin
            n.pre = s.pre - PW'(1);
        end
        if (!board || tm == TM_OFF) begin
            n.timer = '0;
            n.armed = 1'b1;
        end else if ((tm == TM_FVWAIT) && fval_rise) begin
            n.timer = s.period;
            n.armed = 1'b1;
        end else if (trig) begin
            n.timer = s.period;
            n.armed = 1'b0;
        end else if (s.pre == '0 && s.timer != '0) begin
            n.timer = s.timer - 32'h1;
        end
        if (trig) begin
            n.pulse = PULSE_CYCLES;
        end else if (s.pulse != '0) begin
            n.pulse = s.pulse - 8'h1;
        end
        n.expose = (n.pulse != '0);

        // Frame tagger; two words of margin cover the registered ready and push
        space_ok = fifo_ready && (fifo_level < LW'(FIFO_DEPTH - 2));
        accept = PIX_VALID && s.pix_ready;
        n.push_valid = 1'b0;
        n.sync_err = 1'b0;
        case (s.st)
            TG_IDLE: begin
                if (accept && tagging) begin
                    n.sync_err = 1'b1;
                end
                if (fval_rise) begin
                    n.frames = s.frames + 32'h1;
                    n.wcnt = '0;
                    n.hcnt = '0;
                    n.st = (tagging && hp == HP_BEFORE) ? TG_HEAD : TG_PIX;
                end
            end
            TG_HEAD, TG_TAIL: begin
                if (space_ok) begin
                    n.push_valid = 1'b1;
                    n.push_word = hdr_word(s.hcnt, s.frames);
                    n.hcnt = s.hcnt + 2'h1;
                    if (s.hcnt == 2'(HDR_WORDS - 1)) begin
                        n.st = (s.st == TG_HEAD) ? TG_PIX : TG_IDLE;
                    end
                end
            end
            TG_PIX: begin
                if (accept) begin
                    n.push_valid = 1'b1;
                    n.wcnt = s.wcnt + 32'h1;
                    if (tagging && hp == HP_WITHIN && s.wcnt < HDR_WORDS) begin
                        n.push_word = hdr_word(s.wcnt[1:0], s.frames);
                    end else begin
                        n.push_word.tag = 1'b0;
                        n.push_word.data = PIX_DATA;
                    end
                end
                if (fval_fall) begin
                    // A short or long frame means the DMA lost its place
                    n.sync_err = tagging && (n.wcnt != s.fsize);
                    n.hcnt = '0;
                    n.st = (tagging && hp == HP_AFTER) ? TG_TAIL : TG_IDLE;
                end
            end
            default: n.st = TG_IDLE;
        endcase
        n.pix_ready = (n.st == TG_PIX || n.st == TG_IDLE) && space_ok;
        n.acq_tmo = n.sync_err && (fsm == FS_TIMEOUT);
        // A new event beats a clear in the same cycle
        n.sync_flag = n.sync_err || (s.sync_flag && !clr[STAT_SYNC_BIT]);
        n.tmo_flag = n.acq_tmo || (s.tmo_flag && !clr[STAT_TMO_BIT]);
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.armed <= 1'b1;
            s.ctrl <= CTRL_RST;
            s.period <= PERIOD_RST;
            s.fsize <= FSIZE_RST;
            s.st <= TG_IDLE;
        end else if (CE) begin
            s <= n;
        end
    end

    word_fifo #(
        .WIDTH($bits(word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RSTN),
        .ce(CE),
        .s_valid(s.push_valid),
        .s_ready(fifo_ready),
        .s_data(s.push_word),
        .m_valid(OUT_VALID),
        .m_ready(OUT_READY),
        .m_data(OUT_WORD),
        .level(fifo_level)
    );

    assign AWREADY = s.awready;
    assign WREADY = s.wready;
    assign BVALID = s.bvalid;
    assign BRESP = s.bresp;
    assign ARREADY = s.arready;
    assign RVALID = s.rvalid;
    assign RRESP = s.rresp;
    assign RDATA = s.rdata;
    assign PIX_READY = s.pix_ready;
    assign EXPOSE = s.expose;
    assign SYNC_ERR = s.sync_err;
    assign ACQ_TIMEOUT = s.acq_tmo;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    property p_periodic_reload;
        CE && trig && tm == TM_PERIODIC |=> s.timer == $past(s.period) && s.pulse == PULSE_CYCLES;
    endproperty
    a_periodic_reload: assert property (p_periodic_reload)
        else $error("periodic trigger did not reload the timer");

    property p_wait_holds;
        board && tm == TM_FVWAIT && s.timer != '0 |-> !trig;
    endproperty
    a_wait_holds: assert property (p_wait_holds)
        else $error("trigger issued before the frame timer expired");

    property p_fval_trigger;
        CE && board && tm == TM_OFF && fval_rise |=> EXPOSE && s.pulse == PULSE_CYCLES;
    endproperty
    a_fval_trigger: assert property (p_fval_trigger)
        else $error("no trigger on frame valid rise");

    property p_board_only;
        !board |-> !trig;
    endproperty
    a_board_only: assert property (p_board_only)
        else $error("trigger without board trigger source");

    property p_expose_line;
        CE && trig |=> EXPOSE [*2];
    endproperty
    a_expose_line: assert property (p_expose_line)
        else $error("expose line not driven by trigger");

    property p_readout_load;
        CE && board && tm == TM_FVWAIT && fval_rise |=> s.timer == $past(s.period) && s.armed;
    endproperty
    a_readout_load: assert property (p_readout_load)
        else $error("readout start did not load the frame timer");

    property p_marker;
        s.push_valid && s.push_word.tag |-> s.push_word.data == SOF_MARKER;
    endproperty
    a_marker: assert property (p_marker)
        else $error("tagged header word lacks the marker");

    property p_sync_flag;
        SYNC_ERR |-> s.sync_flag ##1 (s.sync_flag || $past(wr_go));
    endproperty
    a_sync_flag: assert property (p_sync_flag)
        else $error("sync error not recorded");

    property p_timeout;
        ACQ_TIMEOUT |-> SYNC_ERR && s.tmo_flag;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout without sync error");

    property p_tick;
        CE && board && tm == TM_PERIODIC && !trig && s.pre != '0 |=> s.timer == $past(s.timer);
    endproperty
    a_tick: assert property (p_tick)
        else $error("timer moved between microsecond ticks");

    property p_stop;
        CE && !board |=> s.timer == '0 && s.armed && (s.pulse == '0 || s.pulse < $past(s.pulse));
    endproperty
    a_stop: assert property (p_stop)
        else $error("frame timer kept running while disabled");
endmodule // frame_trigger_timer_and_sync_tagger
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the frame trigger timer and sync tagger.
// Assumes the camera model answers expose pulses; bus master is AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
    import frame_timer_pkg::*;
    typedef struct {addr_t a; logic [31:0] d; logic [31:0] rd; logic [1:0] rsp;} row_t;
    logic mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, out_ready = 1'b1, kick = 1'b0;
    addr_t awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, pix_data, v;
    logic [7:0] cam_words = 8'h04;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, fval, pix_valid, pix_ready;
    logic out_valid, expose, sync_err, acq_tmo, ex_q, fv_q;
    word_t out_word;
    word_t outq[$];
    int failures = 0, samples_checked = 0, nsync, ntmo, nboth, n, mi;
    row_t rows[6] = '{'{REG_CTRL, 32'h26, 32'h26, RESP_OKAY},
        '{REG_PERIOD, 32'h186a0, 32'h186a0, RESP_OKAY}, '{REG_FSIZE, 32'h4, 32'h4, RESP_OKAY},
        '{REG_FRAMES, 32'hff, 32'h0, RESP_OKAY}, '{REG_TIMER, 32'h55, 32'h0, RESP_OKAY},
        '{8'h18, 32'h1, 32'h0, RESP_SLVERR}};
    logic [31:0] quiet[4] = '{32'h1, 32'h2, 32'h1000, 32'h2001};
    wire ex_rise = expose && !ex_q;

    frame_trigger_timer_and_sync_tagger #(.PULSE_CYCLES(8'h02)) dut (
        .MCLK(mclk), .RSTN(rstn), .CE(1'b1), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .FVAL_IN(fval), .PIX_DATA(pix_data), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
        .OUT_WORD(out_word), .OUT_VALID(out_valid), .OUT_READY(out_ready), .EXPOSE(expose),
        .SYNC_ERR(sync_err), .ACQ_TIMEOUT(acq_tmo));
    camera_model #(.LAG(20)) cam (.clk(mclk), .rst_n(rstn), .expose(expose), .kick(kick),
        .words(cam_words), .fval(fval), .pix_data(pix_data), .pix_valid(pix_valid),
        .pix_ready(pix_ready));

    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        ex_q <= expose;
        fv_q <= fval;
        if (out_valid && out_ready) outq.push_back(out_word);
        if (sync_err) nsync++;
        if (acq_tmo) ntmo++;
        if (sync_err && acq_tmo) nboth++;
    end

    task automatic wr(input addr_t a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge mclk);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input addr_t a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge mclk);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic edges_to_rise(output int c);
        c = 0;
        do begin
            @(posedge mclk);
            c++;
        end while (!ex_rise);
    endtask
    task automatic frame(input logic [31:0] ctrl, input logic [7:0] w, input int exp_n);
        wr(REG_CTRL, ctrl, r);
        outq.delete();
        nsync = 0;
        ntmo = 0;
        nboth = 0;
        cam_words <= w;
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
        do @(posedge mclk); while (outq.size() < exp_n);
        repeat (8) @(posedge mclk);
        `CHK("word count", exp_n, outq.size())
    endtask
    task automatic conclude();
        $display("checked %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        conclude();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, r);
            `CHK("bresp", rows[i].rsp, r)
            rd(rows[i].a, v, r);
            `CHK("rdata", rows[i].rd, v)
            `CHK("rresp", rows[i].rsp, r)
        end
        $display("test registers done");
        for (int p = 1; p <= 2; p++) begin
            wr(REG_CTRL, 32'h0, r);
            wr(REG_PERIOD, 32'(p), r);
            wr(REG_CTRL, 32'h1001, r);
            edges_to_rise(n);
            edges_to_rise(n);
            `CHK("trigger spacing", 100 * p, n)
        end
        $display("test periodic done");
        foreach (quiet[i]) begin
            wr(REG_CTRL, quiet[i], r);
            repeat (60) @(posedge mclk);
            n = 0;
            repeat (300) begin
                @(posedge mclk);
                if (ex_rise) n++;
            end
            `CHK("no trigger", 0, n)
            rd(REG_TIMER, v, r);
            `CHK("timer stopped", 32'h0, v)
        end
        $display("test trigger gating done");
        wr(REG_CTRL, 32'h1000, r);
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
        edges_to_rise(n);
        `CHK("trigger on frame valid", 1'b1, n >= 3 && n <= 8)
        // A pulse landing inside the running frame would be ignored by the camera
        do @(posedge mclk); while (fval);
        wr(REG_PERIOD, 32'h1, r);
        wr(REG_CTRL, 32'h1002, r);
        edges_to_rise(n);
        do @(posedge mclk); while (!(fval && !fv_q));
        edges_to_rise(n);
        `CHK("wait after readout", 1'b1, n >= 101 && n <= 107)
        $display("test frame valid wait done");
        wr(REG_CTRL, 32'h0, r);
        repeat (80) @(posedge mclk);
        for (int hp = 0; hp <= 2; hp++) begin
            frame(32'h4 | 32'(hp << 4), 8'h04, hp == 0 ? 4 : 6);
            mi = hp == 2 ? 4 : 0;
            `CHK("marker", {1'b1, SOF_MARKER}, outq[mi])
            mi = hp == 2 ? 0 : 2;
            `CHK("first pixel", {1'b0, 32'h100 + (hp == 0 ? 2 : 0)}, outq[mi])
            `CHK("no sync error", 0, nsync)
        end
        frame(32'h14, 8'h03, 5);
        `CHK("short frame flagged", 1, nsync)
        `CHK("no timeout", 0, ntmo)
        frame(32'h18, 8'h05, 7);
        `CHK("long frame flagged", 1, nsync)
        `CHK("timeout with error", 1, nboth)
        rd(REG_STATUS, v, r);
        `CHK("status flags", 2'h3, v[1:0])
        wr(REG_STATUS, 32'h3, r);
        rd(REG_STATUS, v, r);
        `CHK("flags cleared", 2'h0, v[1:0])
        frame(32'h0, 8'h04, 4);
        `CHK("untagged start", {1'b0, 32'h100}, outq[0])
        $display("test tagging done");
        outq.delete();
        out_ready <= 1'b0;
        cam_words <= 8'd20;
        kick <= 1'b1;
        @(posedge mclk);
        kick <= 1'b0;
        n = 0;
        repeat (100) begin
            @(posedge mclk);
            if (pix_valid && !pix_ready) n++;
        end
        `CHK("full buffer refuses", 1'b1, n > 0)
        `CHK("nothing leaves", 0, outq.size())
        out_ready <= 1'b1;
        do @(posedge mclk); while (outq.size() < 20);
        `CHK("last word", {1'b0, 32'h113}, outq[19])
        $display("test buffer done");
        wr(REG_PERIOD, 32'h1, r);
        wr(REG_CTRL, 32'h1001, r);
        repeat (50) @(posedge mclk);
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("expose in reset", 1'b0, expose)
        `CHK("out valid in reset", 1'b0, out_valid)
        rstn <= 1'b1;
        rd(REG_CTRL, v, r);
        `CHK("ctrl after reset", CTRL_RST, v)
        $display("test reset done");
        conclude();
    end
endmodule // testbench
`default_nettype wire

// ---- word_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides and a registered fill level.
// Assumes one clock; the clock enable freezes all state.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] cnt;
    } fifo_state_t;
    fifo_state_t s, n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    always_comb begin
        n = s;
        push = s_valid && s_ready;
        pop = m_valid && m_ready;
        if (push) begin
            n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
        end
        if (pop) begin
            n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
        end
        if (push && !pop) begin
            n.cnt = s.cnt + LW'(1);
        end else if (pop && !push) begin
            n.cnt = s.cnt - LW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[s.wp] <= s_data;
        end
    end

    assign s_ready = (s.cnt != LW'(DEPTH));
    assign m_valid = (s.cnt != '0);
    assign m_data = mem[s.rp];
    assign level = s.cnt;
endmodule // word_fifo
`default_nettype wire
